// >>> rtl/cfg_agent_regs.vh
// How it works
// - write request: token 192, 24-bit reply id, 16-bit reg number, 32-bit data, token 1
// - write reply: tokens 3 then 1 on success, tokens 4 then 1 on failure
// - read request: token 193, 24-bit reply id, 16-bit reg number, token 1
// - read reply: token 3, 32 data bits, token 1; or tokens 4 and 1
// - request carries upper 24 bits of reply channel-end; reply is sent there
// - reply id with low 8 bits all ones suppresses the write reply
// - multi-byte fields travel most significant byte first
// - status registers are read and written a whole word at a time locally
// - status resource id is register number shifted left 8, ored with 0x0c
// - ram base resets to 0x00010000; bits 31:2 writable, bits 1:0 read-only
// - vector target: upper 16 from vector base 31:16, lower 16 from event vector
`ifndef CFG_AGENT_REGS_VH
`define CFG_AGENT_REGS_VH

// ****************************************
// message tokens
// ****************************************
`define TOK_WRITE_REQ   8'hc0
`define TOK_READ_REQ    8'hc1
`define TOK_END         8'h01
`define TOK_ACK         8'h03
`define TOK_NACK        8'h04
`define NO_REPLY_LOW    8'hff
`define PS_RES_TYPE     8'h0c

// ****************************************
// register numbers
// ****************************************
`define REG_RAM_BASE    8'h00
`define REG_VEC_BASE    8'h01
`define REG_TILE_CTRL   8'h02
`define REG_BOOT_STAT   8'h03
`define REG_SECURITY    8'h05
`define REG_RING_CTRL   8'h06
`define REG_RING_CNT0   8'h07
`define REG_RING_CNT3   8'h0a
`define REG_DBG_SSR     8'h10
`define REG_DBG_SPC     8'h11
`define REG_DBG_SSP     8'h12
`define REG_DBG_CORE    8'h13
`define REG_DBG_REGSEL  8'h14
`define REG_DBG_CAUSE   8'h15
`define REG_DBG_INFO    8'h16
`define REG_DBG_CTRL    8'h18
`define REG_DBG_SCRATCH 8'h20
`define REG_IBRK_ADDR   8'h30
`define REG_IBRK_CTRL   8'h40
`define REG_DWCH_LOW    8'h50
`define REG_DWCH_HIGH   8'h60
`define REG_DWCH_CTRL   8'h70
`define REG_RWCH_MASK   8'h80
`define REG_RWCH_VALUE  8'h90
`define REG_RWCH_CTRL   8'h9c

// ****************************************
// reset values and field masks
// ****************************************
`define RAM_BASE_RESET  32'h00010000
`define RAM_BASE_MASK   32'hfffffffc
`define VEC_BASE_MASK   32'hffff0000
`define TILE_CTRL_MASK  32'h00000030
`define RING_CTRL_MASK  32'h00000003
`define CORE_SEL_MASK   32'h000000ff
`define REG_SEL_MASK    32'h0000001f
`define CAUSE_MASK      32'h00030000

`endif

// >>> rtl/status_reg_bank.v
`timescale 1ns/1ps
`include "cfg_agent_regs.vh"

// ****************************************
// processor status register bank
// ****************************************
module status_reg_bank (
   input  wire        clock_in,
   input  wire        reset_n_in,
   input  wire [7:0]  num_in,
   input  wire        wr_in,
   input  wire [31:0] wdata_in,
   input  wire [31:0] ext_boot_in,
   input  wire [31:0] ext_security_in,
   input  wire [63:0] ext_ring_in,
   output reg  [31:0] rdata_out,
   output reg         ok_out,
   output reg         ro_out,
   output wire [31:0] ram_base_out,
   output wire [15:0] vec_hi_out,
   output wire [1:0]  tile_ctrl_out,
   output wire [1:0]  ring_ctrl_out
);
   reg [31:0] ram_base;
   reg [31:0] vec_base;
   reg [31:0] tile_ctrl;
   reg [31:0] ring_ctrl;
   reg [31:0] bank [0:63];   // debug, scratch and breakpoint groups, indexed by a compressed slot
   reg [5:0]  slot;
   reg        slot_ok;
   reg [31:0] slot_mask;
   integer    i;
   wire [1:0] ring_idx;

   // 0x07..0x0a wrap onto counts 0..3; two bits keep the index in range
   assign ring_idx      = num_in[1:0] + 2'd1;
   assign ram_base_out  = ram_base;
   assign vec_hi_out    = vec_base[31:16];
   assign tile_ctrl_out = tile_ctrl[5:4];
   assign ring_ctrl_out = ring_ctrl[1:0];

   // map debug/breakpoint numbers onto bank slots; unlisted numbers fail
   always @* begin
      slot      = 6'h00;
      slot_ok   = 1'b1;
      slot_mask = 32'hffffffff;
      if (num_in >= `REG_DBG_SSR && num_in <= `REG_DBG_INFO) begin
         slot = {2'b00, num_in[3:0]};
         if (num_in == `REG_DBG_CORE) slot_mask = `CORE_SEL_MASK;
         if (num_in == `REG_DBG_REGSEL) slot_mask = `REG_SEL_MASK;
         if (num_in == `REG_DBG_CAUSE) slot_mask = `CAUSE_MASK;
      end else if (num_in == `REG_DBG_CTRL) slot = 6'h07;   // 7 is free, 8 up is scratch
      else if (num_in[7:3] == 5'h04) slot = {3'b001, num_in[2:0]};
      // breakpoint groups 0x30..0x80 take four slots each from 16 up
      else if (num_in >= `REG_IBRK_ADDR && num_in <= (`REG_RWCH_MASK | 8'h03)
               && num_in[3:2] == 2'b00) slot = 6'h10 + {num_in[7:4] - 4'h3, num_in[1:0]};
      else if (num_in[7:2] == 6'h24) slot = {4'hb, num_in[1:0]};
      else if (num_in[7:2] == 6'h27) slot = {4'hc, num_in[1:0]};
      else slot_ok = 1'b0;
   end

   // whole-word read decode
   always @* begin
      rdata_out = 32'h00000000;
      ok_out    = 1'b1;
      ro_out    = 1'b0;
      case (num_in)
         `REG_RAM_BASE:  rdata_out = ram_base;
         `REG_VEC_BASE:  rdata_out = vec_base;
         `REG_TILE_CTRL: rdata_out = tile_ctrl;
         `REG_BOOT_STAT: begin rdata_out = ext_boot_in; ro_out = 1'b1; end
         `REG_SECURITY:  begin rdata_out = ext_security_in; ro_out = 1'b1; end
         `REG_RING_CTRL: rdata_out = ring_ctrl;
         default: begin
            if (num_in >= `REG_RING_CNT0 && num_in <= `REG_RING_CNT3) begin
               rdata_out = {16'h0000, ext_ring_in[{ring_idx, 4'h0} +: 16]};
               ro_out    = 1'b1;
            end else if (slot_ok) rdata_out = bank[slot];
            else ok_out = 1'b0;
         end
      endcase
   end

   // whole-word writes, reserved bits held at zero
   always @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         ram_base  <= `RAM_BASE_RESET;
         vec_base  <= 32'h00000000;
         tile_ctrl <= 32'h00000000;
         ring_ctrl <= 32'h00000000;
         for (i = 0; i < 64; i = i + 1) bank[i] <= 32'h00000000;
      end else if (wr_in && ok_out && !ro_out) begin
         case (num_in)
            `REG_RAM_BASE:  ram_base  <= wdata_in & `RAM_BASE_MASK;
            `REG_VEC_BASE:  vec_base  <= wdata_in & `VEC_BASE_MASK;
            `REG_TILE_CTRL: tile_ctrl <= wdata_in & `TILE_CTRL_MASK;
            `REG_RING_CTRL: ring_ctrl <= wdata_in & `RING_CTRL_MASK;
            default:        bank[slot] <= wdata_in & slot_mask;
         endcase
      end
   end
endmodule // status_reg_bank

// >>> rtl/config_register_access_agent.v
`timescale 1ns/1ps
`include "cfg_agent_regs.vh"

// ****************************************
// configuration access agent
// ****************************************
module config_register_access_agent (
   input  wire        clock_in,
   input  wire        reset_n_in,
   // request byte stream from the channel
   input  wire        rx_valid_in,
   input  wire        rx_ctrl_in,
   input  wire [7:0]  rx_data_in,
   output wire        rx_ready_out,
   // reply byte stream to the channel
   output reg         tx_valid_out,
   output reg         tx_ctrl_out,
   output reg  [7:0]  tx_data_out,
   output reg  [23:0] tx_dest_out,
   input  wire        tx_ready_in,
   // local processor status access
   input  wire        ps_req_in,
   input  wire        ps_write_in,
   input  wire [31:0] ps_resource_in,
   input  wire [31:0] ps_wdata_in,
   output reg  [31:0] ps_rdata_out,
   output reg         ps_ok_out,
   output reg         ps_done_out,
   // event vectoring
   input  wire [15:0] event_vector_in,
   output wire [31:0] event_target_out,
   // read-only sources and register outputs
   input  wire [31:0] boot_status_in,
   input  wire [31:0] security_in,
   input  wire [63:0] ring_counts_in,
   output wire [31:0] ram_base_out,
   output wire [1:0]  tile_ctrl_out,
   output wire [1:0]  ring_ctrl_out
);
   localparam S_IDLE  = 3'd0;
   localparam S_ID    = 3'd1;
   localparam S_NUM   = 3'd2;
   localparam S_DATA  = 3'd3;
   localparam S_END   = 3'd4;
   localparam S_EXEC  = 3'd5;
   localparam S_REPLY = 3'd6;

   reg  [2:0]  state;
   reg  [2:0]  cnt;
   reg         is_write;
   reg         bad;
   reg  [23:0] reply_id;
   reg  [15:0] reg_num;
   reg  [31:0] wdata;
   reg  [31:0] rdata_hold;
   reg         success;
   reg  [2:0]  tx_idx;
   reg  [2:0]  tx_len;

   wire        ps_sel;
   wire [7:0]  bank_num;
   wire        bank_wr;
   wire [31:0] bank_wdata;
   wire [31:0] bank_rdata;
   wire        bank_ok;
   wire        bank_ro;
   wire [15:0] vec_hi;
   wire        num_hit;
   wire        rx_take;

   // local status access has priority in every state except S_EXEC
   assign ps_sel     = ps_req_in && (state != S_EXEC);
   assign bank_num   = ps_sel ? ps_resource_in[15:8] : reg_num[7:0];
   assign bank_wr    = ps_sel ? (ps_write_in && ps_resource_in[7:0] == `PS_RES_TYPE)
                              : (state == S_EXEC && is_write && num_hit && !bad);
   assign bank_wdata = ps_sel ? ps_wdata_in : wdata;
   assign num_hit    = (reg_num[15:8] == 8'h00) && bank_ok && !(is_write && bank_ro);
   assign rx_ready_out = (state != S_EXEC) && (state != S_REPLY);
   assign rx_take    = rx_valid_in && rx_ready_out;
   // upper half from the vector base, lower half from the event
   assign event_target_out = {vec_hi, event_vector_in};

   status_reg_bank u_bank (
      .clock_in        (clock_in),
      .reset_n_in      (reset_n_in),
      .num_in          (bank_num),
      .wr_in           (bank_wr),
      .wdata_in        (bank_wdata),
      .ext_boot_in     (boot_status_in),
      .ext_security_in (security_in),
      .ext_ring_in     (ring_counts_in),
      .rdata_out       (bank_rdata),
      .ok_out          (bank_ok),
      .ro_out          (bank_ro),
      .ram_base_out    (ram_base_out),
      .vec_hi_out      (vec_hi),
      .tile_ctrl_out   (tile_ctrl_out),
      .ring_ctrl_out   (ring_ctrl_out)
   );

   // local status answer, one cycle after the request
   always @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         ps_done_out  <= 1'b0;
         ps_ok_out    <= 1'b0;
         ps_rdata_out <= 32'h00000000;
      end else begin
         ps_done_out  <= ps_sel;
         ps_ok_out    <= ps_sel && bank_ok && ps_resource_in[7:0] == `PS_RES_TYPE
                         && !(ps_write_in && bank_ro);
         if (ps_sel) ps_rdata_out <= bank_rdata;
      end
   end

   // request parser: token, id, number, data, end token
   always @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state      <= S_IDLE;
         cnt        <= 3'd0;
         is_write   <= 1'b0;
         bad        <= 1'b0;
         reply_id   <= 24'h000000;
         reg_num    <= 16'h0000;
         wdata      <= 32'h00000000;
         rdata_hold <= 32'h00000000;
         success    <= 1'b0;
      end else begin
         case (state)
            S_IDLE: begin
               if (rx_take && rx_ctrl_in) begin
                  // stray data and unknown tokens are dropped here
                  if (rx_data_in == `TOK_WRITE_REQ || rx_data_in == `TOK_READ_REQ) begin
                     is_write <= (rx_data_in == `TOK_WRITE_REQ);
                     bad      <= 1'b0;
                     cnt      <= 3'd0;
                     state    <= S_ID;
                  end
               end
            end
            S_ID: begin
               if (rx_take) begin
                  reply_id <= {reply_id[15:0], rx_data_in};
                  bad      <= bad | rx_ctrl_in;
                  cnt      <= (cnt == 3'd2) ? 3'd0 : cnt + 3'd1;
                  if (cnt == 3'd2) state <= S_NUM;
               end
            end
            S_NUM: begin
               if (rx_take) begin
                  reg_num <= {reg_num[7:0], rx_data_in};
                  bad     <= bad | rx_ctrl_in;
                  cnt     <= (cnt == 3'd1) ? 3'd0 : cnt + 3'd1;
                  if (cnt == 3'd1) state <= is_write ? S_DATA : S_END;
               end
            end
            S_DATA: begin
               if (rx_take) begin
                  wdata <= {wdata[23:0], rx_data_in};
                  bad   <= bad | rx_ctrl_in;
                  cnt   <= (cnt == 3'd3) ? 3'd0 : cnt + 3'd1;
                  if (cnt == 3'd3) state <= S_END;
               end
            end
            S_END: begin
               // a malformed frame still ends on its last byte, end token or not, and fails
               if (rx_take) begin
                  if (!(rx_ctrl_in && rx_data_in == `TOK_END)) bad <= 1'b1;
                  state <= S_EXEC;
               end
            end
            S_EXEC: begin
               success    <= num_hit && !bad;
               rdata_hold <= bank_rdata;
               // all-ones low byte asks for a silent write
               state      <= (is_write && reply_id[7:0] == `NO_REPLY_LOW) ? S_IDLE : S_REPLY;
            end
            S_REPLY: begin
               if (tx_valid_out && tx_ready_in && tx_idx == tx_len) state <= S_IDLE;
            end
            default: state <= S_IDLE;
         endcase
      end
   end

   // reply length: ack/nack plus end, with four data bytes on a good read
   always @* begin
      tx_len = (success && !is_write) ? 3'd5 : 3'd1;
   end

   // reply serialiser, registered outputs
   always @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         tx_valid_out <= 1'b0;
         tx_ctrl_out  <= 1'b0;
         tx_data_out  <= 8'h00;
         tx_dest_out  <= 24'h000000;
         tx_idx       <= 3'd0;
      end else if (state != S_REPLY) begin
         tx_valid_out <= 1'b0;
         tx_idx       <= 3'd0;
      end else if (!tx_valid_out || tx_ready_in) begin
         if (tx_valid_out && tx_idx == tx_len) begin
            tx_valid_out <= 1'b0;
         end else begin
            tx_valid_out <= 1'b1;
            tx_dest_out  <= reply_id;
            tx_idx       <= tx_valid_out ? tx_idx + 3'd1 : 3'd0;
            case (tx_valid_out ? tx_idx + 3'd1 : 3'd0)
               3'd0: begin
                  tx_ctrl_out <= 1'b1;
                  tx_data_out <= success ? `TOK_ACK : `TOK_NACK;
               end
               3'd1: begin
                  tx_ctrl_out <= !(success && !is_write);
                  tx_data_out <= (success && !is_write) ? rdata_hold[31:24] : `TOK_END;
               end
               3'd2: begin tx_ctrl_out <= 1'b0; tx_data_out <= rdata_hold[23:16]; end
               3'd3: begin tx_ctrl_out <= 1'b0; tx_data_out <= rdata_hold[15:8]; end
               3'd4: begin tx_ctrl_out <= 1'b0; tx_data_out <= rdata_hold[7:0]; end
               default: begin tx_ctrl_out <= 1'b1; tx_data_out <= `TOK_END; end
            endcase
         end
      end
   end
endmodule // config_register_access_agent

// >>> sim/cfg_agent_chk.sv
`timescale 1ns/1ps

// ****************************************
// port checker for the access agent
// ****************************************
module cfg_agent_chk (
   input wire        clock_in,
   input wire        reset_n_in,
   input wire        rx_ready_out,
   input wire        tx_valid_out,
   input wire        tx_ctrl_out,
   input wire [7:0]  tx_data_out,
   input wire [23:0] tx_dest_out,
   input wire        tx_ready_in,
   input wire        ps_req_in,
   input wire [31:0] ps_resource_in,
   input wire        ps_ok_out,
   input wire        ps_done_out,
   input wire [15:0] event_vector_in,
   input wire [31:0] event_target_out,
   input wire [31:0] ram_base_out
);
   reg  mid_frame;
   wire tx_take = tx_valid_out && tx_ready_in;

   // inside a reply once its opening token left; a data byte of 01 is no end
   always @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in)
         mid_frame <= 1'b0;
      else if (tx_take)
         mid_frame <= !(tx_ctrl_out && tx_data_out == 8'h01);
   end

   default clocking @(posedge clock_in); endclocking
   default disable iff (!reset_n_in);

   chk_ram_reset: assert property ($rose(reset_n_in) |-> ram_base_out == 32'h00010000)
      else $error("ram base wrong after reset");
   chk_ram_low: assert property (ram_base_out[1:0] == 2'b00)
      else $error("ram base low bits not zero");
   chk_vec_target: assert property (event_target_out[15:0] == event_vector_in)
      else $error("vector target low half wrong");
   chk_tx_hold: assert property (tx_valid_out && !tx_ready_in |=>
      tx_valid_out && $stable({tx_ctrl_out, tx_data_out, tx_dest_out}))
      else $error("reply byte changed before accept");
   chk_dest_stable: assert property (tx_valid_out && mid_frame |-> $stable(tx_dest_out))
      else $error("reply destination moved inside frame");
   chk_reply_start: assert property (tx_valid_out && !mid_frame |-> tx_ctrl_out &&
      (tx_data_out == 8'h03 || tx_data_out == 8'h04))
      else $error("reply opens with wrong token");
   chk_nack_end: assert property (tx_take && tx_ctrl_out && tx_data_out == 8'h04 |=>
      !tx_valid_out || (tx_ctrl_out && tx_data_out == 8'h01))
      else $error("failure token not followed by end");
   chk_rx_blocked: assert property (tx_valid_out |-> !rx_ready_out)
      else $error("request taken while replying");
   chk_ps_done: assert property (ps_req_in |-> ##[1:2] ps_done_out)
      else $error("local access never completed");
   chk_ps_type: assert property (ps_done_out && $past(ps_resource_in[7:0]) != 8'h0c
      |-> !ps_ok_out)
      else $error("wrong resource type accepted");

   cov_ack: cover property (tx_take && tx_ctrl_out && tx_data_out == 8'h03);
   cov_nack: cover property (tx_take && tx_ctrl_out && tx_data_out == 8'h04);
   cov_ps_ok: cover property (ps_done_out && ps_ok_out);
endmodule // cfg_agent_chk

bind config_register_access_agent cfg_agent_chk chk (
   .clock_in(clock_in), .reset_n_in(reset_n_in), .rx_ready_out(rx_ready_out),
   .tx_valid_out(tx_valid_out), .tx_ctrl_out(tx_ctrl_out), .tx_data_out(tx_data_out),
   .tx_dest_out(tx_dest_out), .tx_ready_in(tx_ready_in), .ps_req_in(ps_req_in),
   .ps_resource_in(ps_resource_in), .ps_ok_out(ps_ok_out), .ps_done_out(ps_done_out),
   .event_vector_in(event_vector_in), .event_target_out(event_target_out),
   .ram_base_out(ram_base_out));

// >>> sim/chan_end_model.sv
`timescale 1ns/1ps
`include "cfg_agent_regs.vh"

// ****************************************
// remote channel end issuing requests
// ****************************************
module chan_end_model (
   input  wire       clock_in,
   input  wire       reset_n_in,
   input  wire       slow_in,
   input  wire       req_ready_in,
   output reg        req_valid_out,
   output reg        req_ctrl_out,
   output reg  [7:0] req_data_out,
   output wire       rep_ready_out,
   output reg        stuck_out
);
   // destinations a requester programs; the agent only ever sees the payload
   localparam [31:0] tile_dest = 32'h0001c20c;
   localparam [31:0] node_dest = 32'h0002c30c;
   reg [2:0] pace = 3'h0;

   // sink stalls half the time when slow, like a busy core
   always @(posedge clock_in) pace <= pace + 3'h1;
   assign rep_ready_out = !slow_in || pace[1];

   initial begin
      req_valid_out = 1'b0;
      req_ctrl_out = 1'b0;
      req_data_out = 8'h00;
      stuck_out = 1'b0;
   end

   // hold one byte until the agent takes it
   task put_byte(input c, input [7:0] d);
      integer k;
      begin
         req_valid_out <= 1'b1;
         req_ctrl_out <= c;
         req_data_out <= d;
         @(posedge clock_in);
         for (k = 0; k < 100 && req_ready_in !== 1'b1; k = k + 1) @(posedge clock_in);
         if (req_ready_in !== 1'b1) stuck_out <= 1'b1;
      end
   endtask

   // whole frame, fields most significant byte first
   task request(input wr, input [23:0] id, input [15:0] num, input [31:0] d,
                input [7:0] end_tok);
      integer i;
      begin
         put_byte(1'b1, wr ? `TOK_WRITE_REQ : `TOK_READ_REQ);
         for (i = 2; i >= 0; i = i - 1) put_byte(1'b0, id[i*8 +: 8]);
         for (i = 1; i >= 0; i = i - 1) put_byte(1'b0, num[i*8 +: 8]);
         if (wr)
            for (i = 3; i >= 0; i = i - 1) put_byte(1'b0, d[i*8 +: 8]);
         put_byte(1'b1, end_tok);
         req_valid_out <= 1'b0;
         req_data_out <= ~req_data_out; // released line must not look valid
      end
   endtask
endmodule // chan_end_model

// >>> sim/tb.sv
`timescale 1ns/1ps

// ****************************************
// bench for the configuration access agent
// ****************************************
module tb;
   reg         clock_in, reset_n_in, slow, ps_req, ps_write;
   reg  [31:0] ps_resource, ps_wdata, boot_status, security, d, seed;
   reg  [15:0] event_vector;
   reg  [63:0] ring_counts;
   reg  [23:0] id;
   reg  [32:0] exp_byte;
   wire        rx_valid, rx_ctrl, rx_ready, tx_valid, tx_ctrl, tx_ready, ps_ok, ps_done, stuck;
   wire [7:0]  rx_data, tx_data;
   wire [23:0] tx_dest;
   wire [31:0] ps_rdata, event_target, ram_base;
   wire [1:0]  tile_ctrl, ring_ctrl;
   integer     n_fail, n_compared, i;
   reg  [32:0] q[$];
   localparam [95:0] bad_num = {16'h0000, 16'h000a, 16'h0100, 16'h0004, 16'h0005, 16'h0003};
   localparam [5:0]  bad_wr = 6'b010011;

   config_register_access_agent dut (.clock_in(clock_in), .reset_n_in(reset_n_in),
      .rx_valid_in(rx_valid), .rx_ctrl_in(rx_ctrl), .rx_data_in(rx_data),
      .rx_ready_out(rx_ready), .tx_valid_out(tx_valid), .tx_ctrl_out(tx_ctrl),
      .tx_data_out(tx_data), .tx_dest_out(tx_dest), .tx_ready_in(tx_ready),
      .ps_req_in(ps_req), .ps_write_in(ps_write), .ps_resource_in(ps_resource),
      .ps_wdata_in(ps_wdata), .ps_rdata_out(ps_rdata), .ps_ok_out(ps_ok),
      .ps_done_out(ps_done), .event_vector_in(event_vector), .event_target_out(event_target),
      .boot_status_in(boot_status), .security_in(security), .ring_counts_in(ring_counts),
      .ram_base_out(ram_base), .tile_ctrl_out(tile_ctrl), .ring_ctrl_out(ring_ctrl));

   chan_end_model far (.clock_in(clock_in), .reset_n_in(reset_n_in), .slow_in(slow),
      .req_ready_in(rx_ready), .req_valid_out(rx_valid), .req_ctrl_out(rx_ctrl),
      .req_data_out(rx_data), .rep_ready_out(tx_ready), .stuck_out(stuck));

   function [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task finish_test;
      if (n_fail == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task check(input string what, input [31:0] exp, input [31:0] got);
      n_compared = n_compared + 1;
      if (got !== exp) begin
         n_fail = n_fail + 1;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   // note the reply bytes a request should bring back
   task expect_reply(input good, input rd, input [31:0] v);
      integer k;
      begin
         q.push_back({1'b1, good ? 8'h03 : 8'h04, id});
         if (good && rd)
            for (k = 3; k >= 0; k = k - 1) q.push_back({1'b0, v[k*8 +: 8], id});
         q.push_back({1'b1, 8'h01, id});
      end
   endtask

   task req(input wr, input [23:0] rid, input [15:0] num, input [31:0] v, input [7:0] e);
      @(posedge clock_in);
      far.request(wr, rid, num, v, e);
   endtask

   // bounded wait for the noted replies, then a quiet gap to catch strays
   task drain;
      integer k;
      begin
         for (k = 0; k < 300 && q.size() != 0; k = k + 1) @(posedge clock_in);
         check("pending_replies", 32'h0, q.size());
         if (q.size() != 0) finish_test;
         repeat (8) @(posedge clock_in);
      end
   endtask

   task ps_access(input wr, input [15:0] num, input [7:0] kind, input [31:0] wd,
                  input ok, input [31:0] rd);
      integer k;
      begin
         @(posedge clock_in);
         ps_req <= 1'b1;
         ps_write <= wr;
         ps_resource <= {8'h00, num, kind};
         ps_wdata <= wd;
         @(posedge clock_in);
         ps_req <= 1'b0;
         #1;
         for (k = 0; k < 4 && ps_done !== 1'b1; k = k + 1) @(posedge clock_in) #1;
         check("ps_done", 32'h1, {31'h0, ps_done});
         check("ps_ok", {31'h0, ok}, {31'h0, ps_ok});
         if (!wr && ok) check("ps_rdata", rd, ps_rdata);
      end
   endtask

   // reply checker: every accepted byte against the oldest note
   always @(posedge clock_in) begin
      if (reset_n_in && tx_valid && tx_ready) begin
         exp_byte = 33'bx;
         if (q.size() != 0) exp_byte = q.pop_front();
         n_compared = n_compared + 1;
         if ({tx_ctrl, tx_data, tx_dest} !== exp_byte) begin
            n_fail = n_fail + 1;
            $display("mismatch reply_byte expected %h seen %h", exp_byte,
                     {tx_ctrl, tx_data, tx_dest});
         end
      end
      if (stuck === 1'b1) begin
         n_fail = n_fail + 1;
         $display("mismatch request_accept expected 1 seen 0");
         finish_test;
      end
   end

   initial begin
      clock_in = 1'b0;
      forever #2.5 clock_in = ~clock_in;
   end

   initial begin
      {seed, n_fail, n_compared} = {32'h40, 32'h0, 32'h0};
      {reset_n_in, slow, ps_req, ps_write, ps_resource, ps_wdata} = 'h0;
      {event_vector, boot_status, security, ring_counts} = 'h0;
      repeat (20) @(posedge clock_in);
      reset_n_in <= 1'b1;
      boot_status <= rnd();
      ring_counts <= {rnd(), rnd()};
      @(posedge clock_in);
      #1;
      check("ram_base_reset", 32'h00010000, ram_base);
      d = rnd();
      id = {d[23:8], 8'h3c};
      d = rnd();
      expect_reply(1'b1, 1'b0, 32'h0);
      req(1'b1, id, 16'h0000, d, 8'h01);
      drain;
      check("ram_base_out", d & 32'hfffffffc, ram_base);
      slow <= 1'b1;
      expect_reply(1'b1, 1'b1, d & 32'hfffffffc);
      req(1'b0, id, 16'h0000, 32'h0, 8'h01);
      drain;
      slow <= 1'b0;
      d = rnd();
      req(1'b1, {id[23:8], 8'hff}, 16'h0001, d, 8'h01);
      drain;
      event_vector <= d[15:0] ^ 16'h5a5a;
      @(posedge clock_in);
      #1;
      check("event_target", {d[31:16], d[15:0] ^ 16'h5a5a}, event_target);
      expect_reply(1'b1, 1'b1, d & 32'hffff0000);
      req(1'b0, id, 16'h0001, 32'h0, 8'h01);
      drain;
      // unknown numbers, read-only targets and a broken end token all fail
      for (i = 0; i < 6; i = i + 1) begin
         expect_reply(1'b0, 1'b0, 32'h0);
         req(bad_wr[i], id, bad_num[i*16 +: 16], rnd(), (i == 5) ? 8'h02 : 8'h01);
         drain;
      end
      expect_reply(1'b1, 1'b1, boot_status);
      req(1'b0, id, 16'h0003, 32'h0, 8'h01);
      drain;
      expect_reply(1'b1, 1'b1, {16'h0000, ring_counts[31:16]});
      req(1'b0, id, 16'h0008, 32'h0, 8'h01);
      drain;
      // back to back: second request waits on the first reply
      d = rnd();
      expect_reply(1'b1, 1'b0, 32'h0);
      expect_reply(1'b1, 1'b1, d & 32'h00000030);
      req(1'b1, id, 16'h0002, d, 8'h01);
      req(1'b0, id, 16'h0002, 32'h0, 8'h01);
      drain;
      check("tile_ctrl_out", {30'h0, d[5:4]}, {30'h0, tile_ctrl});
      ps_access(1'b1, 16'h0006, 8'h0c, 32'hffffffff, 1'b1, 32'h0);
      ps_access(1'b0, 16'h0006, 8'h0c, 32'h0, 1'b1, 32'h00000003);
      check("ring_ctrl_out", 32'h3, {30'h0, ring_ctrl});
      ps_access(1'b0, 16'h0006, 8'h0d, 32'h0, 1'b0, 32'h0);
      ps_access(1'b1, 16'h0000, 8'h0c, 32'h12345677, 1'b1, 32'h0);
      check("ram_base_local", 32'h12345674, ram_base);
      // debug and breakpoint slots must not alias one another
      ps_access(1'b1, 16'h0018, 8'h0c, 32'h0000a5a5, 1'b1, 32'h0);
      ps_access(1'b1, 16'h0020, 8'h0c, 32'h00005a5a, 1'b1, 32'h0);
      ps_access(1'b1, 16'h0070, 8'h0c, 32'hffffffff, 1'b1, 32'h0);
      ps_access(1'b0, 16'h0018, 8'h0c, 32'h0, 1'b1, 32'h0000a5a5);
      ps_access(1'b0, 16'h0010, 8'h0c, 32'h0, 1'b1, 32'h0);
      ps_access(1'b0, 16'h0007, 8'h0c, 32'h0, 1'b1, {16'h0000, ring_counts[15:0]});
      finish_test;
   end
endmodule // tb
